// *** scar_cfg.svh ***
`ifndef SCAR_CFG_SVH
`define SCAR_CFG_SVH
// ----------------------------------------
// Coprocessor move encodings (crn, crm, opc2)
// ----------------------------------------
`define SCAR_CRN_C1 4'h1
`define SCAR_CRM_C0 4'h0
`define SCAR_CRM_C1 4'h1
`define SCAR_OPC2_CPACC 3'h2
`define SCAR_OPC2_SECCFG 3'h0
`define SCAR_OPC2_SDBG 3'h1
`define SCAR_OPC2_NSACC 3'h2
// ----------------------------------------
// Coprocessor access rights fields
// ----------------------------------------
`define SCAR_COPROCESSOR_ELEVEN_ACCESS_HI 23
`define SCAR_COPROCESSOR_ELEVEN_ACCESS_LO 22
`define SCAR_COPROCESSOR_TEN_ACCESS_HI 21
`define SCAR_COPROCESSOR_TEN_ACCESS_LO 20
`define SCAR_ACC_DENIED 2'h0
`define SCAR_ACC_PRIV 2'h1
`define SCAR_ACC_RSVD 2'h2
`define SCAR_ACC_FULL 2'h3
// ----------------------------------------
// Secure configuration fields
// ----------------------------------------
`define SCAR_SC_NS 0
`define SCAR_SC_IRQ 1
`define SCAR_SC_FIQ 2
`define SCAR_SC_EA 3
`define SCAR_SC_FW 4
`define SCAR_SC_AW 5
`define SCAR_SC_WIDTH 6
`define SCAR_SC_RESET 6'h00
// ----------------------------------------
// Secure debug enable fields
// ----------------------------------------
`define SCAR_SD_INV 0
`define SCAR_SD_NINV 1
`define SCAR_SD_RESET 2'h0
// ----------------------------------------
// Nonsecure access control fields
// ----------------------------------------
`define SCAR_NA_COPROCESSOR_TEN_ACCESS 10
`define SCAR_NA_COPROCESSOR_ELEVEN_ACCESS 11
`define SCAR_NA_TL 17
`define SCAR_NA_RESET 3'h0
`endif

// *** scar_pkg.sv ***
`default_nettype none
// ----------------------------------------
// Types for the secure configuration bank
// ----------------------------------------
package scar_pkg;
  // Processor mode class seen by the bank
  typedef enum logic [1:0] {
    SCAR_MODE_USER = 2'b00,
    SCAR_MODE_PRIV = 2'b01,
    SCAR_MODE_MON = 2'b11
  } scar_mode_t;
  // One register move from the pipeline
  typedef struct packed {
    logic valid;
    logic write;
    logic [3:0] crn;
    logic [3:0] crm;
    logic [2:0] opc2;
    logic [31:0] wdata;
    scar_mode_t mode;
  } scar_req_t;
  // Answer to the pipeline
  typedef struct packed {
    logic hit;
    logic undef;
    logic [31:0] rdata;
  } scar_rsp_t;
  // Coprocessor use check request
  typedef struct packed {
    logic valid;
    logic coprocessor_eleven_access;
    logic priv;
  } scar_cpuse_t;
endpackage
`default_nettype wire

// *** scar_cp_field.sv ***
`include "scar_cfg.svh"
`default_nettype none
// ----------------------------------------
// One two-bit coprocessor access field
// ----------------------------------------
module scar_cp_field #(
  parameter bit PRESENT = 1'b1
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wr_en,
  input wire logic [1:0] wr_val,
  input wire logic use_priv,
  output logic [1:0] field,
  output logic allow
);
  // Absent coprocessors keep the denied code
  wire [1:0] next_field = PRESENT ? wr_val : `SCAR_ACC_DENIED;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      field <= `SCAR_ACC_DENIED;
    end else if (wr_en) begin
      field <= next_field;
    end
  end
  assign allow = (field == `SCAR_ACC_FULL) || ((field == `SCAR_ACC_PRIV) && use_priv);
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Absent stays denied
  AST_ABSENT_DENIED: assert property (@(posedge clk) disable iff (sys_rst)
    !PRESENT |-> field == `SCAR_ACC_DENIED)
    else $error("absent field not denied");
  AST_RSVD_DENY: assert property (@(posedge clk) disable iff (sys_rst)
    field == `SCAR_ACC_RSVD |-> !allow)
    else $error("reserved code granted access");
endmodule
`default_nettype wire

// *** scar_regs.sv ***
// Contract
// - Access rights reachable at c1,c0,2
// - Absent coprocessor field stays b00
// - Decode denied, privileged, reserved, full
// - Reset sets all fields denied
// - Secure config secure privileged only
// - Bit0 selects nonsecure state, resets 0
// - Monitor mode always counts as secure
// - Bit1 routes interrupts to monitor
// - Bit2 routes fast interrupts to monitor
// - Bit3 routes aborts, secure fault copies
// - Bit4 lets nonsecure modify fast mask
// - Bit5 lets nonsecure modify abort mask
// - Bit6 zero; upper bits read zero
// - Debug enable secure privileged only
// - Debug bits: noninvasive, invasive
// - Nonsecure control secure write, nonsecure read
// - Bit17 lockable entries allow; bit16 zero
// - No effect on debug, system coprocessors
// - Access fields at 23:22 and 21:20
// - Bits 11,10 grant nonsecure coprocessor use
// - Nonsecure control reachable at c1,c1,2
`include "scar_cfg.svh"
`default_nettype none
module scar_regs #(
  parameter bit COPROCESSOR_TEN_ACCESS_PRESENT = 1'b1,
  parameter bit COPROCESSOR_ELEVEN_ACCESS_PRESENT = 1'b1
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire scar_pkg::scar_req_t req,
  output scar_pkg::scar_rsp_t rsp,
  input wire scar_pkg::scar_cpuse_t cpuse,
  output logic cpuse_undef,
  output logic secure_now,
  output logic nonsecure_state_select,
  output logic irq_monitor_route,
  output logic fast_interrupt_monitor_route,
  output logic external_abort_monitor_route,
  output logic fault_to_secure_copy,
  output logic fast_mask_modify_enable,
  output logic abort_mask_modify_enable,
  output logic secure_user_invasive_debug,
  output logic secure_user_noninvasive_debug,
  output logic lockable_tlb_allow
);
  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [`SCAR_SC_WIDTH-1:0] sec_cfg; // Secure configuration bits 5..0
  logic [1:0] dbg_en; // Secure debug enable bits 1..0
  logic tl_bit; // Lockable entry allow
  logic ns_coprocessor_ten_access; // Nonsecure grant for coprocessor 10
  logic ns_coprocessor_eleven_access; // Nonsecure grant for coprocessor 11
  logic [1:0] coprocessor_ten_access_field; // Access field coprocessor 10
  logic [1:0] coprocessor_eleven_access_field; // Access field coprocessor 11
  logic coprocessor_ten_access_allow; // Field permits this use
  logic coprocessor_eleven_access_allow; // Field permits this use

  // ----------------------------------------
  // Mode and state
  // ----------------------------------------
  // Monitor forces secure
  wire is_mon = (req.mode == scar_pkg::SCAR_MODE_MON);
  assign secure_now = is_mon || !sec_cfg[`SCAR_SC_NS];
  wire is_priv = (req.mode != scar_pkg::SCAR_MODE_USER); // Privileged incl. monitor
  wire sec_priv = secure_now && is_priv; // Secure privileged

  // ----------------------------------------
  // Encoding decode
  // ----------------------------------------
  wire crn_ok = req.valid && (req.crn == `SCAR_CRN_C1);
  wire hit_cpacc = crn_ok && (req.crm == `SCAR_CRM_C0) && (req.opc2 == `SCAR_OPC2_CPACC);
  wire hit_sc = crn_ok && (req.crm == `SCAR_CRM_C1) && (req.opc2 == `SCAR_OPC2_SECCFG);
  wire hit_sd = crn_ok && (req.crm == `SCAR_CRM_C1) && (req.opc2 == `SCAR_OPC2_SDBG);
  wire hit_na = crn_ok && (req.crm == `SCAR_CRM_C1) && (req.opc2 == `SCAR_OPC2_NSACC);
  wire any_hit = hit_cpacc || hit_sc || hit_sd || hit_na;

  // ----------------------------------------
  // Permission checks
  // ----------------------------------------
  // Secure privileged only
  wire bad_sc = hit_sc && !sec_priv;
  wire bad_sd = hit_sd && !sec_priv;
  wire bad_na = hit_na && (!is_priv || (!secure_now && req.write));
  wire bad_cpacc = hit_cpacc && !is_priv; // User mode refused
  wire undef_now = bad_sc || bad_sd || bad_na || bad_cpacc;
  wire ok_wr = req.write && !undef_now; // Accepted write

  // Write strobes
  wire wr_sc = hit_sc && ok_wr;
  wire wr_sd = hit_sd && ok_wr;
  wire wr_na = hit_na && ok_wr;
  // Nonsecure writes reach a field only if granted; else ignored
  wire wr_coprocessor_ten_access = hit_cpacc && ok_wr && (secure_now || ns_coprocessor_ten_access);
  wire wr_coprocessor_eleven_access = hit_cpacc && ok_wr && (secure_now || ns_coprocessor_eleven_access);
  // Write data slices for secure config, debug enable and the lockable bit
  wire [`SCAR_SC_WIDTH-1:0] sc_wdata = req.wdata[`SCAR_SC_WIDTH-1:0];
  wire [1:0] sd_wdata = req.wdata[1:0];
  wire na_tl_wdata = req.wdata[`SCAR_NA_TL];

  // ----------------------------------------
  // Secure configuration register
  // ----------------------------------------
  // Reset clears all bits
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sec_cfg <= `SCAR_SC_RESET;
    end else if (wr_sc) begin
      sec_cfg <= sc_wdata;
    end
  end

  // ----------------------------------------
  // Secure debug enable register
  // ----------------------------------------
  // Two debug bits
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dbg_en <= `SCAR_SD_RESET;
    end else if (wr_sd) begin
      dbg_en <= sd_wdata;
    end
  end

  // ----------------------------------------
  // Nonsecure access control register
  // ----------------------------------------
  // Lockable bit, bit16 ignored
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      {tl_bit, ns_coprocessor_eleven_access, ns_coprocessor_ten_access} <= `SCAR_NA_RESET;
    end else if (wr_na) begin
      {tl_bit, ns_coprocessor_eleven_access, ns_coprocessor_ten_access} <= {req.wdata[`SCAR_NA_TL], req.wdata[`SCAR_NA_COPROCESSOR_ELEVEN_ACCESS], req.wdata[`SCAR_NA_COPROCESSOR_TEN_ACCESS]};
    end
  end

  // ----------------------------------------
  // Access rights fields
  // ----------------------------------------
  // Privilege of the checked coprocessor use
  wire use_priv = cpuse.priv;
  scar_cp_field #(.PRESENT(COPROCESSOR_TEN_ACCESS_PRESENT)) u_coprocessor_ten_access (
    .clk(clk),
    .sys_rst(sys_rst),
    .wr_en(wr_coprocessor_ten_access),
    .wr_val(req.wdata[`SCAR_COPROCESSOR_TEN_ACCESS_HI:`SCAR_COPROCESSOR_TEN_ACCESS_LO]),
    .use_priv(use_priv),
    .field(coprocessor_ten_access_field),
    .allow(coprocessor_ten_access_allow)
  );
  scar_cp_field #(.PRESENT(COPROCESSOR_ELEVEN_ACCESS_PRESENT)) u_coprocessor_eleven_access (
    .clk(clk),
    .sys_rst(sys_rst),
    .wr_en(wr_coprocessor_eleven_access),
    .wr_val(req.wdata[`SCAR_COPROCESSOR_ELEVEN_ACCESS_HI:`SCAR_COPROCESSOR_ELEVEN_ACCESS_LO]),
    .use_priv(use_priv),
    .field(coprocessor_eleven_access_field),
    .allow(coprocessor_eleven_access_allow)
  );

  // ----------------------------------------
  // Coprocessor use check
  // ----------------------------------------
  // Only coprocessors 10, 11 gated
  wire ns_grant = cpuse.coprocessor_eleven_access ? ns_coprocessor_eleven_access : ns_coprocessor_ten_access;
  wire fld_allow = cpuse.coprocessor_eleven_access ? coprocessor_eleven_access_allow : coprocessor_ten_access_allow;
  assign cpuse_undef = cpuse.valid && (!fld_allow || (!secure_now && !ns_grant));

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  // Nonsecure read of an ungranted field shows b00
  wire [1:0] rd_coprocessor_ten_access = (secure_now || ns_coprocessor_ten_access) ? coprocessor_ten_access_field : `SCAR_ACC_DENIED;
  wire [1:0] rd_coprocessor_eleven_access = (secure_now || ns_coprocessor_eleven_access) ? coprocessor_eleven_access_field : `SCAR_ACC_DENIED;
  wire [31:0] rd_sc = {26'h000_0000, sec_cfg};
  wire [31:0] rd_sd = {30'h0000_0000, dbg_en};
  wire [31:0] rd_na = {14'h0000, tl_bit, 5'h00, ns_coprocessor_eleven_access, ns_coprocessor_ten_access, 10'h000};
  wire [31:0] rd_cp = {8'h00, rd_coprocessor_eleven_access, rd_coprocessor_ten_access, 20'h0_0000};
  wire [31:0] rd_sel = hit_sc ? rd_sc : hit_sd ? rd_sd : hit_na ? rd_na : hit_cpacc ? rd_cp : 32'h0000_0000;

  // Answer registered one cycle after the request
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rsp <= '0;
    end else begin
      rsp.hit <= any_hit;
      rsp.undef <= undef_now;
      rsp.rdata <= (any_hit && !req.write && !undef_now) ? rd_sel : 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // Control outputs
  // ----------------------------------------
  assign nonsecure_state_select = sec_cfg[`SCAR_SC_NS];
  assign irq_monitor_route = sec_cfg[`SCAR_SC_IRQ];
  assign fast_interrupt_monitor_route = sec_cfg[`SCAR_SC_FIQ];
  assign external_abort_monitor_route = sec_cfg[`SCAR_SC_EA];
  assign fault_to_secure_copy = sec_cfg[`SCAR_SC_EA];
  assign fast_mask_modify_enable = sec_cfg[`SCAR_SC_FW];
  assign abort_mask_modify_enable = sec_cfg[`SCAR_SC_AW];
  assign secure_user_invasive_debug = dbg_en[`SCAR_SD_INV];
  assign secure_user_noninvasive_debug = dbg_en[`SCAR_SD_NINV];
  assign lockable_tlb_allow = tl_bit;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Nonsecure access refused
  AST_SC_UNDEF: assert property (@(posedge clk) disable iff (sys_rst)
    hit_sc && !is_mon && nonsecure_state_select |=> rsp.undef)
    else $error("nonsecure secure-config access not refused");
  AST_SC_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
    hit_sc && req.write && !sec_priv |=> $stable(sec_cfg))
    else $error("refused write changed secure config");
  AST_MON_SECURE: assert property (@(posedge clk) disable iff (sys_rst)
    is_mon |-> secure_now)
    else $error("monitor mode not secure");
  AST_SC_WRITE: assert property (@(posedge clk) disable iff (sys_rst)
    wr_sc |=> sec_cfg == $past(sc_wdata) && rsp.rdata == 32'h0000_0000)
    else $error("secure config write lost");
  AST_SC_READ: assert property (@(posedge clk) disable iff (sys_rst)
    hit_sc && !req.write && sec_priv |=> rsp.rdata == {26'h000_0000, sec_cfg})
    else $error("secure config read wrong");
  AST_SD_UNDEF: assert property (@(posedge clk) disable iff (sys_rst)
    hit_sd && !secure_now |=> rsp.undef)
    else $error("nonsecure debug access not refused");
  AST_SD_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
    hit_sd && req.write && !sec_priv |=> $stable(dbg_en))
    else $error("refused write changed debug enable");
  AST_SD_WRITE: assert property (@(posedge clk) disable iff (sys_rst)
    wr_sd |=> dbg_en == $past(sd_wdata))
    else $error("debug enable write lost");
  AST_SD_READ: assert property (@(posedge clk) disable iff (sys_rst)
    hit_sd && !req.write && sec_priv |=> rsp.rdata == {30'h0000_0000, dbg_en})
    else $error("debug enable read wrong");
  AST_NA_RO: assert property (@(posedge clk) disable iff (sys_rst)
    hit_na && req.write && !secure_now |=> rsp.undef && $stable(tl_bit))
    else $error("nonsecure write to access control");
  AST_NA_USER: assert property (@(posedge clk) disable iff (sys_rst)
    hit_na && !is_priv |=> rsp.undef)
    else $error("user access to access control");
  AST_NA_READ: assert property (@(posedge clk) disable iff (sys_rst)
    hit_na && !req.write && is_priv |=>
      !rsp.undef && rsp.rdata[16] == 1'b0 && rsp.rdata[17] == tl_bit)
    else $error("access control read wrong");
  AST_NA_WRITE: assert property (@(posedge clk) disable iff (sys_rst)
    wr_na |=> lockable_tlb_allow == $past(na_tl_wdata))
    else $error("lockable allow write lost");
  AST_CP_USER: assert property (@(posedge clk) disable iff (sys_rst)
    hit_cpacc && !is_priv |=> rsp.undef)
    else $error("user access to access rights");
  AST_CP_READ: assert property (@(posedge clk) disable iff (sys_rst)
    hit_cpacc && !req.write && is_priv && secure_now |=>
      rsp.rdata[23:22] == coprocessor_eleven_access_field && rsp.rdata[21:20] == coprocessor_ten_access_field)
    else $error("access field read wrong");
  AST_CP_NS_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
    hit_cpacc && req.write && !secure_now && !ns_coprocessor_ten_access |=> $stable(coprocessor_ten_access_field))
    else $error("ungranted nonsecure write changed field");
  AST_CP_NS_MASK: assert property (@(posedge clk) disable iff (sys_rst)
    hit_cpacc && !req.write && is_priv && !secure_now && !ns_coprocessor_ten_access |=> rsp.rdata[21:20] == `SCAR_ACC_DENIED)
    else $error("ungranted nonsecure read shows field");
  AST_NS_GRANT: assert property (@(posedge clk) disable iff (sys_rst)
    cpuse.valid && !secure_now && !ns_grant |-> cpuse_undef)
    else $error("ungranted nonsecure use allowed");
  AST_USE_SECURE: assert property (@(posedge clk) disable iff (sys_rst)
    cpuse.valid && secure_now && fld_allow |-> !cpuse_undef)
    else $error("secure permitted use refused");
  AST_USE_DENIED: assert property (@(posedge clk) disable iff (sys_rst)
    cpuse.valid && !fld_allow |-> cpuse_undef)
    else $error("denied use allowed");
  AST_USE_IDLE: assert property (@(posedge clk) disable iff (sys_rst)
    !cpuse.valid |-> !cpuse_undef)
    else $error("refusal without a use");
endmodule
`default_nettype wire

// *** scar_core_model.sv ***
`include "scar_cfg.svh"
`default_nettype none
// ----------------------------------------
// Core pipeline issuing register moves
// ----------------------------------------
module scar_core_model (
  input wire logic clk,
  output scar_pkg::scar_req_t req,
  input wire scar_pkg::scar_rsp_t rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle pipeline at time zero
  initial begin
    req = '0;
  end
  // One move: present after falling edge, taken at rising edge, answer next cycle
  task automatic move(input logic wr, input logic [3:0] crm, input logic [2:0] opc2,
                      input logic [31:0] wdata, input scar_pkg::scar_mode_t mode,
                      output scar_pkg::scar_rsp_t got);
    @(negedge clk);
    req.valid = 1'b1;
    req.write = wr;
    req.crn = `SCAR_CRN_C1;
    req.crm = crm;
    req.opc2 = opc2;
    req.wdata = wdata;
    req.mode = mode;
    @(negedge clk);
    got = rsp;
    req.valid = 1'b0;
    // Released data bus does not keep its last value
    req.wdata = ~wdata;
    if (wr && crm == `SCAR_CRM_C0) begin
      @(negedge clk);
    end
  endtask
endmodule
`default_nettype wire

// *** tb.sv ***
`include "scar_cfg.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Signals and constants
  // ----------------------------------------
  localparam logic [3:0] c0 = `SCAR_CRM_C0;
  localparam logic [3:0] c1 = `SCAR_CRM_C1;
  localparam scar_pkg::scar_mode_t usr = scar_pkg::SCAR_MODE_USER;
  localparam scar_pkg::scar_mode_t prv = scar_pkg::SCAR_MODE_PRIV;
  localparam scar_pkg::scar_mode_t mon = scar_pkg::SCAR_MODE_MON;
  logic clk, sys_rst, cpuse_undef, secure_now, ns_sel, irq_r, fiq_r, ea_r;
  logic fault_cp, fw, aw, inv, ninv, tl;
  scar_pkg::scar_req_t req;
  scar_pkg::scar_rsp_t rsp;
  scar_pkg::scar_cpuse_t cpuse;
  int num_errors, samples_checked;
  // Coprocessor 11 absent to see its field stay denied
  scar_regs #(.COPROCESSOR_TEN_ACCESS_PRESENT(1'b1), .COPROCESSOR_ELEVEN_ACCESS_PRESENT(1'b0)) scar_regs_i (
    .clk(clk), .sys_rst(sys_rst), .req(req), .rsp(rsp), .cpuse(cpuse), .cpuse_undef(cpuse_undef),
    .secure_now(secure_now), .nonsecure_state_select(ns_sel), .irq_monitor_route(irq_r),
    .fast_interrupt_monitor_route(fiq_r), .external_abort_monitor_route(ea_r),
    .fault_to_secure_copy(fault_cp), .fast_mask_modify_enable(fw), .abort_mask_modify_enable(aw),
    .secure_user_invasive_debug(inv), .secure_user_noninvasive_debug(ninv), .lockable_tlb_allow(tl));
  scar_core_model scar_core_model_i (.clk(clk), .req(req), .rsp(rsp));
  // Free running clock
  always #20 clk = ~clk;
  // ----------------------------------------
  // Compare, access and closing tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One move; read data compared on reads only
  task automatic acc(input logic wr, input logic [3:0] crm, input logic [2:0] opc2, input logic [31:0] d,
                     input scar_pkg::scar_mode_t m, input logic u, input logic [31:0] exp);
    scar_pkg::scar_rsp_t got;
    scar_core_model_i.move(wr, crm, opc2, d, m, got);
    check("hit and undef", {30'h0, 1'b1, u}, {30'h0, got.hit, got.undef});
    if (!wr) begin
      check("read data", exp, got.rdata);
    end
  endtask
  // Coprocessor use presented after a falling edge, refusal read before the next rising edge
  task automatic use_chk(input string what, input logic coprocessor_eleven_access, input logic pr, input logic exp);
    @(negedge clk);
    cpuse = {1'b1, coprocessor_eleven_access, pr};
    #1;
    check(what, {31'h0, exp}, {31'h0, cpuse_undef});
    cpuse = '0;
  endtask
  task automatic final_report();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Watchdog on the whole run
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    final_report();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    cpuse = '0;
    num_errors = 0;
    samples_checked = 0;
    repeat (10) @(posedge clk);
    @(negedge clk) sys_rst = 1'b0;
    acc(0, c1, `SCAR_OPC2_SECCFG, 0, prv, 0, 32'h0000_0000);
    acc(0, c1, `SCAR_OPC2_SDBG, 0, prv, 0, 32'h0000_0000);
    acc(0, c1, `SCAR_OPC2_NSACC, 0, prv, 0, 32'h0000_0000);
    acc(0, c0, `SCAR_OPC2_CPACC, 0, prv, 0, 32'h0000_0000);
    // Routing and mask bits each written both set and clear
    acc(1, c1, `SCAR_OPC2_SECCFG, 32'hFFFF_FFCE, prv, 0, 0);
    acc(0, c1, `SCAR_OPC2_SECCFG, 0, prv, 0, 32'h0000_000E);
    check("route bits", 32'h0000_000E, {26'h0, aw, fw, ea_r, fiq_r, irq_r, ns_sel});
    check("fault copy", 32'h0000_0001, fault_cp);
    acc(1, c1, `SCAR_OPC2_SECCFG, 32'h0000_0031, prv, 0, 0);
    check("route bits", 32'h0000_0031, {26'h0, aw, fw, ea_r, fiq_r, irq_r, ns_sel});
    check("state select", 32'h0000_0002, {ns_sel, secure_now});
    acc(0, c1, `SCAR_OPC2_SECCFG, 0, prv, 1, 32'h0000_0000);
    acc(1, c1, `SCAR_OPC2_SDBG, 32'h0000_0003, prv, 1, 0);
    acc(0, c1, `SCAR_OPC2_NSACC, 0, prv, 0, 32'h0000_0000);
    acc(1, c1, `SCAR_OPC2_NSACC, 32'h0002_0C00, prv, 1, 0);
    acc(0, c1, `SCAR_OPC2_NSACC, 0, prv, 0, 32'h0000_0000);
    // Monitor mode counts as secure whatever the state bit
    acc(0, c1, `SCAR_OPC2_SECCFG, 0, mon, 0, 32'h0000_0031);
    check("monitor secure", 32'h0000_0001, secure_now);
    acc(0, c1, `SCAR_OPC2_SDBG, 0, mon, 0, 32'h0000_0000);
    acc(1, c1, `SCAR_OPC2_SECCFG, 32'h0000_000E, mon, 0, 0);
    acc(0, c1, `SCAR_OPC2_SECCFG, 0, usr, 1, 32'h0000_0000);
    acc(1, c1, `SCAR_OPC2_SDBG, 32'hFFFF_FFFF, prv, 0, 0);
    acc(0, c1, `SCAR_OPC2_SDBG, 0, prv, 0, 32'h0000_0003);
    check("debug bits", 32'h0000_0003, {ninv, inv});
    acc(0, c1, `SCAR_OPC2_SDBG, 0, usr, 1, 32'h0000_0000);
    acc(1, c1, `SCAR_OPC2_NSACC, 32'h0003_0C00, prv, 0, 0);
    acc(0, c1, `SCAR_OPC2_NSACC, 0, prv, 0, 32'h0002_0C00);
    check("lockable allow", 32'h0000_0001, tl);
    acc(0, c1, `SCAR_OPC2_NSACC, 0, usr, 1, 32'h0000_0000);
    acc(1, c0, `SCAR_OPC2_CPACC, 32'h00F0_0000, prv, 0, 0);
    acc(0, c0, `SCAR_OPC2_CPACC, 0, prv, 0, 32'h0030_0000);
    acc(0, c0, `SCAR_OPC2_CPACC, 0, usr, 1, 32'h0000_0000);
    // Every access code, used from user and privileged mode
    for (int v = 0; v < 4; v++) begin
      acc(1, c0, `SCAR_OPC2_CPACC, {10'h0, v[1:0], 20'h0_0000}, prv, 0, 0);
      for (int p = 0; p < 2; p++) begin
        use_chk("use refused", 1'b0, p[0], v == 0 || v == 2 || (v == 1 && p == 0));
      end
      use_chk("absent use refused", 1'b1, 1'b1, 1'b1);
    end
    // Nonsecure state with grants: field reachable and usable
    acc(1, c1, `SCAR_OPC2_SECCFG, 32'h0000_0031, prv, 0, 0);
    use_chk("granted use", 1'b0, 1'b0, 1'b0);
    acc(1, c0, `SCAR_OPC2_CPACC, 32'h0010_0000, prv, 0, 0);
    acc(0, c0, `SCAR_OPC2_CPACC, 0, prv, 0, 32'h0010_0000);
    // Grants withdrawn from monitor mode: field hidden, writes ignored, use refused
    acc(1, c1, `SCAR_OPC2_NSACC, 32'h0000_0000, mon, 0, 0);
    acc(0, c0, `SCAR_OPC2_CPACC, 0, prv, 0, 32'h0000_0000);
    acc(1, c0, `SCAR_OPC2_CPACC, 32'h0030_0000, prv, 0, 0);
    use_chk("ungranted use", 1'b0, 1'b1, 1'b1);
    acc(0, c0, `SCAR_OPC2_CPACC, 0, mon, 0, 32'h0010_0000);
    // Second reset in mid-run
    @(negedge clk) sys_rst = 1'b1;
    @(negedge clk) sys_rst = 1'b0;
    acc(0, c0, `SCAR_OPC2_CPACC, 0, prv, 0, 32'h0000_0000);
    acc(0, c1, `SCAR_OPC2_SECCFG, 0, prv, 0, 32'h0000_0000);
    acc(0, c1, `SCAR_OPC2_SDBG, 0, prv, 0, 32'h0000_0000);
    final_report();
  end
endmodule
`default_nettype wire
